//--- include/cmbt_pkg.sv
// Shared types and constants for the move and bit instruction sequencer
package cmbt_pkg;

   // Operations handled by this block
   typedef enum logic [5:0] {
      OP_XOR_DIR_IMM, OP_CLR_ACC, OP_COMP_ACC, OP_ROTL, OP_ROTL_CARRY, OP_ROTR,
      OP_ROTR_CARRY, OP_SWAP_ACC, OP_MOV_A_REG, OP_MOV_A_DIR, OP_MOV_A_IND,
      OP_MOV_A_IMM, OP_MOV_REG_A, OP_MOV_REG_DIR, OP_MOV_REG_IMM, OP_MOV_DIR_A,
      OP_MOV_DIR_REG, OP_MOV_DIR_DIR, OP_MOV_DIR_IND, OP_MOV_DIR_IMM,
      OP_MOV_IND_A, OP_MOV_IND_DIR, OP_MOV_IND_IMM, OP_MOV_DP_IMM16,
      OP_CODE_RD_DP, OP_CODE_RD_PC, OP_EXT_RD_IND, OP_EXT_WR_IND, OP_EXT_RD_DP,
      OP_EXT_WR_DP, OP_PUSH_DIR, OP_POP_DIR, OP_EXCH_REG, OP_EXCH_DIR,
      OP_EXCH_IND, OP_NIB_EXCH, OP_CLR_CARRY, OP_CLR_BIT, OP_SET_CARRY,
      OP_SET_BIT, OP_COMP_CARRY, OP_COMP_BIT
   } cmbt_op_t;

   // Sequencer states, Gray coded
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXEC = 2'h1
   } cmbt_state_t;

   // Encoded lengths in bytes and execution times in cycles
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;

   // Reset values and field positions
   localparam logic [1:0] CNT_RST = 2'h0;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [15:0] DP_RST = 16'h0000;
   localparam int NIB_LO_MSB = 3;
   localparam int NIB_HI_LSB = 4;

   // Request: operation plus the operands fetched by the core around us
   typedef struct packed {
      cmbt_op_t op;
      logic [7:0] src;
      logic [7:0] imm;
      logic [7:0] idx;
      logic [15:0] pc;
      logic bit_in;
   } cmbt_req_t;

   // Length and time of one operation
   typedef struct packed {
      logic [1:0] len;
      logic [1:0] cyc;
   } cmbt_time_t;

   // Architectural result of one operation
   typedef struct packed {
      logic [7:0] acc;
      logic carry;
      logic [7:0] dst;
      logic dst_we;
      logic bit_out;
      logic bit_we;
      logic [15:0] addr;
      logic [15:0] dp;
   } cmbt_res_t;

endpackage

//--- hdl/cmbt_decode.sv
// Length and cycle-time decoder for the move and bit operations
`timescale 1ns/10ps
module cmbt_decode (
   input cmbt_pkg::cmbt_op_t op,
   output cmbt_pkg::cmbt_time_t tim
);

   // Pack a length and a time
   function automatic cmbt_pkg::cmbt_time_t mk(input logic [1:0] l, input logic [1:0] c);
      cmbt_pkg::cmbt_time_t t;
      t.len = l;
      t.cyc = c;
      return t;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Table lookup; unknown codes fall back to the shortest form
   always_comb
   begin
      case (op)
         cmbt_pkg::OP_XOR_DIR_IMM: tim = mk(cmbt_pkg::LEN_THREE, cmbt_pkg::CYC_THREE); // RULE1
         cmbt_pkg::OP_CLR_ACC, cmbt_pkg::OP_ROTL, cmbt_pkg::OP_ROTL_CARRY, cmbt_pkg::OP_ROTR,
         cmbt_pkg::OP_ROTR_CARRY, cmbt_pkg::OP_SWAP_ACC:
            tim = mk(cmbt_pkg::LEN_ONE, cmbt_pkg::CYC_ONE); // RULE2
         cmbt_pkg::OP_COMP_ACC: tim = mk(cmbt_pkg::LEN_ONE, cmbt_pkg::CYC_ONE); // RULE3
         cmbt_pkg::OP_MOV_A_REG, cmbt_pkg::OP_MOV_REG_A, cmbt_pkg::OP_EXCH_REG:
            tim = mk(cmbt_pkg::LEN_ONE, cmbt_pkg::CYC_ONE); // RULE4
         cmbt_pkg::OP_MOV_A_DIR, cmbt_pkg::OP_MOV_A_IMM, cmbt_pkg::OP_MOV_REG_DIR, cmbt_pkg::OP_MOV_REG_IMM,
         cmbt_pkg::OP_MOV_DIR_A, cmbt_pkg::OP_MOV_DIR_REG, cmbt_pkg::OP_MOV_DIR_IND, cmbt_pkg::OP_MOV_IND_DIR,
         cmbt_pkg::OP_MOV_IND_IMM, cmbt_pkg::OP_EXCH_DIR:
            tim = mk(cmbt_pkg::LEN_TWO, cmbt_pkg::CYC_TWO); // RULE5
         cmbt_pkg::OP_MOV_A_IND, cmbt_pkg::OP_MOV_IND_A, cmbt_pkg::OP_EXCH_IND, cmbt_pkg::OP_NIB_EXCH:
            tim = mk(cmbt_pkg::LEN_ONE, cmbt_pkg::CYC_TWO); // RULE6
         cmbt_pkg::OP_MOV_DIR_DIR, cmbt_pkg::OP_MOV_DIR_IMM, cmbt_pkg::OP_MOV_DP_IMM16:
            tim = mk(cmbt_pkg::LEN_THREE, cmbt_pkg::CYC_THREE); // RULE7
         cmbt_pkg::OP_CODE_RD_DP, cmbt_pkg::OP_CODE_RD_PC:
            tim = mk(cmbt_pkg::LEN_ONE, cmbt_pkg::CYC_THREE); // RULE8
         cmbt_pkg::OP_EXT_RD_IND, cmbt_pkg::OP_EXT_WR_IND, cmbt_pkg::OP_EXT_RD_DP, cmbt_pkg::OP_EXT_WR_DP:
            tim = mk(cmbt_pkg::LEN_ONE, cmbt_pkg::CYC_THREE); // RULE9
         cmbt_pkg::OP_PUSH_DIR, cmbt_pkg::OP_POP_DIR: tim = mk(cmbt_pkg::LEN_TWO, cmbt_pkg::CYC_TWO); // RULE11
         cmbt_pkg::OP_CLR_BIT, cmbt_pkg::OP_SET_BIT, cmbt_pkg::OP_COMP_BIT:
            tim = mk(cmbt_pkg::LEN_TWO, cmbt_pkg::CYC_TWO); // RULE12
         cmbt_pkg::OP_CLR_CARRY, cmbt_pkg::OP_SET_CARRY, cmbt_pkg::OP_COMP_CARRY:
            tim = mk(cmbt_pkg::LEN_ONE, cmbt_pkg::CYC_ONE); // RULE13
         default: tim = mk(cmbt_pkg::LEN_ONE, cmbt_pkg::CYC_ONE);
      endcase
   end

endmodule

//--- hdl/cmbt_alu.sv
// Data path: computes the architectural result of one operation
`timescale 1ns/10ps
module cmbt_alu (
   input cmbt_pkg::cmbt_req_t req,
   input cmbt_pkg::cmbt_res_t cur,
   output cmbt_pkg::cmbt_res_t res
);

   localparam int LO = cmbt_pkg::NIB_LO_MSB;
   localparam int HI = cmbt_pkg::NIB_HI_LSB;

   ////////////////////////////////////////////////////////////////////////
   // Start from the current state; write strobes only rise for their ops
   always_comb
   begin
      res = cur;
      res.dst = req.src;
      res.dst_we = 1'b0;
      res.bit_out = req.bit_in;
      res.bit_we = 1'b0;
      res.addr = cur.addr;
      case (req.op)
         cmbt_pkg::OP_XOR_DIR_IMM: begin res.dst = req.src ^ req.imm; res.dst_we = 1'b1; end // RULE1
         cmbt_pkg::OP_CLR_ACC: res.acc = 8'h00; // RULE2
         cmbt_pkg::OP_COMP_ACC: res.acc = ~cur.acc; // RULE3
         cmbt_pkg::OP_ROTL: res.acc = {cur.acc[6:0], cur.acc[7]};
         cmbt_pkg::OP_ROTR: res.acc = {cur.acc[0], cur.acc[7:1]};
         cmbt_pkg::OP_ROTL_CARRY: begin res.acc = {cur.acc[6:0], cur.carry}; res.carry = cur.acc[7]; end
         cmbt_pkg::OP_ROTR_CARRY: begin res.acc = {cur.carry, cur.acc[7:1]}; res.carry = cur.acc[0]; end
         cmbt_pkg::OP_SWAP_ACC: res.acc = {cur.acc[LO:0], cur.acc[7:HI]};
         // Loads into the accumulator
         cmbt_pkg::OP_MOV_A_REG, cmbt_pkg::OP_MOV_A_DIR, cmbt_pkg::OP_MOV_A_IND, cmbt_pkg::OP_MOV_A_IMM:
            res.acc = req.src; // RULE4 RULE5 RULE6
         cmbt_pkg::OP_MOV_REG_A, cmbt_pkg::OP_MOV_DIR_A, cmbt_pkg::OP_MOV_IND_A:
            begin res.dst = cur.acc; res.dst_we = 1'b1; end // RULE4 RULE5 RULE6
         cmbt_pkg::OP_MOV_REG_DIR, cmbt_pkg::OP_MOV_REG_IMM, cmbt_pkg::OP_MOV_DIR_REG, cmbt_pkg::OP_MOV_DIR_DIR,
         cmbt_pkg::OP_MOV_DIR_IND, cmbt_pkg::OP_MOV_DIR_IMM, cmbt_pkg::OP_MOV_IND_DIR, cmbt_pkg::OP_MOV_IND_IMM,
         cmbt_pkg::OP_PUSH_DIR, cmbt_pkg::OP_POP_DIR:
            res.dst_we = 1'b1; // RULE5 RULE7 RULE11
         cmbt_pkg::OP_MOV_DP_IMM16: res.dp = {req.src, req.imm}; // RULE7
         // Code reads: address formed from the accumulator before the load
         cmbt_pkg::OP_CODE_RD_DP: begin res.addr = cur.dp + {8'h00, cur.acc}; res.acc = req.src; end // RULE8
         cmbt_pkg::OP_CODE_RD_PC: begin res.addr = req.pc + {8'h00, cur.acc}; res.acc = req.src; end // RULE8
         cmbt_pkg::OP_EXT_RD_IND: begin res.addr = {8'h00, req.idx}; res.acc = req.src; end // RULE9
         cmbt_pkg::OP_EXT_RD_DP: begin res.addr = cur.dp; res.acc = req.src; end // RULE9
         cmbt_pkg::OP_EXT_WR_IND:
            begin res.addr = {8'h00, req.idx}; res.dst = cur.acc; res.dst_we = 1'b1; end // RULE9
         cmbt_pkg::OP_EXT_WR_DP: begin res.addr = cur.dp; res.dst = cur.acc; res.dst_we = 1'b1; end // RULE9
         cmbt_pkg::OP_EXCH_REG, cmbt_pkg::OP_EXCH_DIR, cmbt_pkg::OP_EXCH_IND:
            begin res.acc = req.src; res.dst = cur.acc; res.dst_we = 1'b1; end // RULE4 RULE5 RULE6
         // Only the low nibbles trade places
         cmbt_pkg::OP_NIB_EXCH:
         begin
            res.acc = {cur.acc[7:HI], req.src[LO:0]}; // RULE10
            res.dst = {req.src[7:HI], cur.acc[LO:0]}; // RULE10
            res.dst_we = 1'b1;
         end
         cmbt_pkg::OP_CLR_CARRY: res.carry = 1'b0; // RULE13
         cmbt_pkg::OP_SET_CARRY: res.carry = 1'b1; // RULE13
         cmbt_pkg::OP_COMP_CARRY: res.carry = ~cur.carry; // RULE13
         cmbt_pkg::OP_CLR_BIT: begin res.bit_out = 1'b0; res.bit_we = 1'b1; end // RULE12
         cmbt_pkg::OP_SET_BIT: begin res.bit_out = 1'b1; res.bit_we = 1'b1; end // RULE12
         cmbt_pkg::OP_COMP_BIT: begin res.bit_out = ~req.bit_in; res.bit_we = 1'b1; end // RULE12
         default: res = cur;
      endcase
   end

endmodule

//--- hdl/cmbt_core.sv
// Sequencer: accepts an operation, holds it for its cycle time, commits it
//
// Contract
// RULE1: XOR immediate into direct byte: three bytes, three cycles.
// RULE2: Clear, rotates and nibble swap of accumulator: one byte, one cycle.
// RULE3: Accumulator complement inverts all eight bits; one byte, one cycle.
// RULE4: Accumulator to or from working register, exchange too: one byte, one cycle.
// RULE5: Two-byte moves and direct exchange take two cycles.
// RULE6: One-byte indirect RAM moves and exchanges take two cycles.
// RULE7: Direct to direct, immediate to direct, pointer load: three bytes, three cycles.
// RULE8: Code reads: one byte, three cycles, address accumulator plus pointer or PC.
// RULE9: External data moves: one byte, three cycles, 8-bit or 16-bit address.
// RULE10: Low nibble exchange swaps only the low nibbles.
// RULE11: Stack push and pop of a direct byte: two bytes, two cycles.
// RULE12: Clear, set, complement direct bit: two bytes, two cycles.
// RULE13: Clear, set, complement carry: one byte, one cycle, carry only.
`timescale 1ns/10ps
module cmbt_core (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic issue_valid,
   input cmbt_pkg::cmbt_req_t issue_req,
   output logic ready_reg,
   output logic done_reg,
   output logic [1:0] len_reg,
   output logic [1:0] cyc_reg,
   output cmbt_pkg::cmbt_res_t res_reg
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   cmbt_pkg::cmbt_state_t state_reg;
   cmbt_pkg::cmbt_state_t state_next;
   cmbt_pkg::cmbt_req_t req_reg;
   cmbt_pkg::cmbt_time_t tim;
   cmbt_pkg::cmbt_res_t alu_res;
   logic [1:0] cnt_reg;
   logic accept;
   logic last;

   ////////////////////////////////////////////////////////////////////////
   // Submodules

   // Timing comes from the incoming op so the count loads at accept
   cmbt_decode u_decode (
      .op (issue_req.op),
      .tim (tim)
   );

   // Result is computed from the held request and the committed state
   cmbt_alu u_alu (
      .req (req_reg),
      .cur (res_reg),
      .res (alu_res)
   );

   ////////////////////////////////////////////////////////////////////////
   // Handshake terms

   // A request is taken only while idle; a busy block ignores issue_valid
   assign accept = issue_valid && ready_reg;
   // Final execution cycle
   assign last = (state_reg == cmbt_pkg::ST_EXEC) && (cnt_reg == cmbt_pkg::CNT_RST);

   ////////////////////////////////////////////////////////////////////////
   // State machine

   // Next state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         cmbt_pkg::ST_IDLE:
         begin
            if (accept)
            begin
               state_next = cmbt_pkg::ST_EXEC;
            end
         end
         cmbt_pkg::ST_EXEC:
         begin
            if (last)
            begin
               state_next = cmbt_pkg::ST_IDLE;
            end
         end
         default: state_next = cmbt_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         state_reg <= cmbt_pkg::ST_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Ready mirrors idle outside reset, which holds it low, and comes from its own flop to keep the port clean
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         ready_reg <= 1'b0;
      end
      else
      begin
         ready_reg <= (state_next == cmbt_pkg::ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cycle counter

   // Loaded with time minus one, so an op stays busy exactly its cycles
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cnt_reg <= cmbt_pkg::CNT_RST;
      end
      else if (accept)
      begin
         cnt_reg <= tim.cyc - 2'h1; // RULE1 RULE5 RULE6 RULE7 RULE8 RULE9 RULE11 RULE12
      end
      else if (state_reg == cmbt_pkg::ST_EXEC && !last)
      begin
         cnt_reg <= cnt_reg - 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request capture

   // Operands are latched once; the source must not be relied on after accept
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         req_reg <= '0;
      end
      else if (accept)
      begin
         req_reg <= issue_req;
      end
   end

   // Length and time of the running op, shown with its completion
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         len_reg <= cmbt_pkg::LEN_ONE;
         cyc_reg <= cmbt_pkg::CYC_ONE;
      end
      else if (accept)
      begin
         len_reg <= tim.len; // RULE1 RULE2 RULE3 RULE4 RULE6 RULE8 RULE9 RULE13
         cyc_reg <= tim.cyc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Commit

   // Done pulses for one cycle as the result lands
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= last;
      end
   end

   // Architectural state; strobes drop after one cycle to avoid double writes
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         res_reg <= '0;
         res_reg.acc <= cmbt_pkg::ACC_RST;
         res_reg.dp <= cmbt_pkg::DP_RST;
      end
      else if (last)
      begin
         res_reg <= alu_res; // RULE2 RULE3 RULE10 RULE13
      end
      else
      begin
         res_reg.dst_we <= 1'b0;
         res_reg.bit_we <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   property p_rule1;
      accept && issue_req.op == cmbt_pkg::OP_XOR_DIR_IMM |=>
         !ready_reg [*3] ##1 (done_reg && len_reg == 2'h3 && res_reg.dst == (req_reg.src ^ req_reg.imm));
   endproperty
   a_rule1: assert property (p_rule1) else $error("xor to direct timing or result wrong"); // RULE1

   property p_rule2;
      accept && issue_req.op inside {cmbt_pkg::OP_CLR_ACC, cmbt_pkg::OP_ROTL, cmbt_pkg::OP_ROTR,
         cmbt_pkg::OP_ROTL_CARRY, cmbt_pkg::OP_ROTR_CARRY, cmbt_pkg::OP_SWAP_ACC} |=>
         !ready_reg ##1 (ready_reg && done_reg && len_reg == 2'h1);
   endproperty
   a_rule2: assert property (p_rule2) else $error("accumulator op not one byte one cycle"); // RULE2

   property p_rule3;
      done_reg && req_reg.op == cmbt_pkg::OP_COMP_ACC |->
         res_reg.acc == ~$past(res_reg.acc) && len_reg == 2'h1 && cyc_reg == 2'h1;
   endproperty
   a_rule3: assert property (p_rule3) else $error("accumulator complement wrong"); // RULE3

   property p_rule4;
      accept && issue_req.op inside {cmbt_pkg::OP_MOV_A_REG, cmbt_pkg::OP_MOV_REG_A,
         cmbt_pkg::OP_EXCH_REG} |=> ##1 (done_reg && len_reg == 2'h1);
   endproperty
   a_rule4: assert property (p_rule4) else $error("register transfer not one cycle"); // RULE4

   property p_rule5;
      accept && issue_req.op inside {cmbt_pkg::OP_MOV_A_DIR, cmbt_pkg::OP_MOV_A_IMM,
         cmbt_pkg::OP_MOV_DIR_A, cmbt_pkg::OP_MOV_IND_IMM, cmbt_pkg::OP_EXCH_DIR} |=>
         !done_reg [*2] ##1 (done_reg && len_reg == 2'h2);
   endproperty
   a_rule5: assert property (p_rule5) else $error("two byte move not two cycles"); // RULE5

   property p_rule6;
      accept && issue_req.op inside {cmbt_pkg::OP_MOV_A_IND, cmbt_pkg::OP_MOV_IND_A,
         cmbt_pkg::OP_EXCH_IND, cmbt_pkg::OP_NIB_EXCH} |=>
         !ready_reg [*2] ##1 (done_reg && len_reg == 2'h1 && cyc_reg == 2'h2);
   endproperty
   a_rule6: assert property (p_rule6) else $error("indirect move not two cycles"); // RULE6

   property p_rule7;
      accept && issue_req.op inside {cmbt_pkg::OP_MOV_DIR_DIR, cmbt_pkg::OP_MOV_DIR_IMM,
         cmbt_pkg::OP_MOV_DP_IMM16} |=> !done_reg [*3] ##1 (done_reg && len_reg == 2'h3);
   endproperty
   a_rule7: assert property (p_rule7) else $error("three byte move not three cycles"); // RULE7

   property p_rule8;
      done_reg && req_reg.op == cmbt_pkg::OP_CODE_RD_DP |->
         res_reg.addr == $past(res_reg.dp) + {8'h00, $past(res_reg.acc)} && cyc_reg == 2'h3;
   endproperty
   a_rule8: assert property (p_rule8) else $error("code read address wrong"); // RULE8

   property p_rule9;
      accept && issue_req.op inside {cmbt_pkg::OP_EXT_RD_IND, cmbt_pkg::OP_EXT_WR_IND,
         cmbt_pkg::OP_EXT_RD_DP, cmbt_pkg::OP_EXT_WR_DP} |=>
         !ready_reg [*3] ##1 (done_reg && len_reg == 2'h1);
   endproperty
   a_rule9: assert property (p_rule9) else $error("external move not three cycles"); // RULE9

   property p_rule10;
      done_reg && req_reg.op == cmbt_pkg::OP_NIB_EXCH |->
         ((res_reg.acc ^ $past(res_reg.acc)) & 8'hf0) == 8'h00 &&
         res_reg.acc[3:0] == req_reg.src[3:0] && res_reg.dst[7:4] == req_reg.src[7:4];
   endproperty
   a_rule10: assert property (p_rule10) else $error("nibble exchange touched high nibble"); // RULE10

   property p_rule11;
      accept && issue_req.op inside {cmbt_pkg::OP_PUSH_DIR, cmbt_pkg::OP_POP_DIR} |=>
         ##2 (done_reg && len_reg == 2'h2 && res_reg.dst_we);
   endproperty
   a_rule11: assert property (p_rule11) else $error("stack op not two cycles"); // RULE11

   property p_rule12;
      accept && issue_req.op inside {cmbt_pkg::OP_CLR_BIT, cmbt_pkg::OP_SET_BIT,
         cmbt_pkg::OP_COMP_BIT} |=> ##2 (done_reg && res_reg.bit_we && len_reg == 2'h2);
   endproperty
   a_rule12: assert property (p_rule12) else $error("bit op not two cycles"); // RULE12

   property p_rule13;
      done_reg && req_reg.op inside {cmbt_pkg::OP_CLR_CARRY, cmbt_pkg::OP_SET_CARRY,
         cmbt_pkg::OP_COMP_CARRY} |-> res_reg.acc == $past(res_reg.acc) && cyc_reg == 2'h1
         && !res_reg.dst_we && !res_reg.bit_we;
   endproperty
   a_rule13: assert property (p_rule13) else $error("carry op touched more than carry"); // RULE13

   // Main scenarios
   c_one_cycle: cover property (accept && tim.cyc == 2'h1 ##2 done_reg);
   c_three_cycle: cover property (accept && tim.cyc == 2'h3 ##4 done_reg);
   c_back_to_back: cover property (done_reg && accept);
   c_nibble: cover property (done_reg && req_reg.op == cmbt_pkg::OP_NIB_EXCH);

endmodule

//--- tb/tb_top.sv
// Self-checking bench for the move and bit instruction sequencer
`timescale 1ns/10ps
module tb_top;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic issue_valid = 1'b0;
   cmbt_pkg::cmbt_req_t issue_req = '0;
   logic ready_reg;
   logic done_reg;
   logic [1:0] len_reg;
   logic [1:0] cyc_reg;
   cmbt_pkg::cmbt_res_t res_reg;
   cmbt_pkg::cmbt_res_t r;
   int n;
   int mismatches = 0;
   int compares = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and unit under test
   always #10 clk_sys = ~clk_sys;

   cmbt_core uut (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .issue_valid(issue_valid),
      .issue_req(issue_req),
      .ready_reg(ready_reg),
      .done_reg(done_reg),
      .len_reg(len_reg),
      .cyc_reg(cyc_reg),
      .res_reg(res_reg)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, seen);
         mismatches++;
      end
   endtask

   function automatic cmbt_pkg::cmbt_req_t mk(input cmbt_pkg::cmbt_op_t o, input logic [7:0] s,
      input logic [7:0] i, input logic [7:0] x, input logic [15:0] p, input logic b);
      mk = '{op: o, src: s, imm: i, idx: x, pc: p, bit_in: b};
   endfunction

   // Expected {length, cycles} worked out per operation group
   function automatic logic [3:0] exp_time(input cmbt_pkg::cmbt_op_t o);
      case (o)
         cmbt_pkg::OP_XOR_DIR_IMM: exp_time = {2'h3, 2'h3};
         cmbt_pkg::OP_CLR_ACC, cmbt_pkg::OP_ROTL, cmbt_pkg::OP_ROTL_CARRY, cmbt_pkg::OP_ROTR,
         cmbt_pkg::OP_ROTR_CARRY, cmbt_pkg::OP_SWAP_ACC, cmbt_pkg::OP_COMP_ACC: exp_time = {2'h1, 2'h1};
         cmbt_pkg::OP_MOV_A_REG, cmbt_pkg::OP_MOV_REG_A, cmbt_pkg::OP_EXCH_REG: exp_time = {2'h1, 2'h1};
         cmbt_pkg::OP_MOV_A_IND, cmbt_pkg::OP_MOV_IND_A, cmbt_pkg::OP_EXCH_IND,
         cmbt_pkg::OP_NIB_EXCH: exp_time = {2'h1, 2'h2};
         cmbt_pkg::OP_MOV_DIR_DIR, cmbt_pkg::OP_MOV_DIR_IMM, cmbt_pkg::OP_MOV_DP_IMM16: exp_time = {2'h3, 2'h3};
         cmbt_pkg::OP_CODE_RD_DP, cmbt_pkg::OP_CODE_RD_PC: exp_time = {2'h1, 2'h3};
         cmbt_pkg::OP_EXT_RD_IND, cmbt_pkg::OP_EXT_WR_IND, cmbt_pkg::OP_EXT_RD_DP,
         cmbt_pkg::OP_EXT_WR_DP: exp_time = {2'h1, 2'h3};
         cmbt_pkg::OP_CLR_CARRY, cmbt_pkg::OP_SET_CARRY, cmbt_pkg::OP_COMP_CARRY: exp_time = {2'h1, 2'h1};
         default: exp_time = {2'h2, 2'h2};
      endcase
   endfunction

   // One request: waits for idle, holds it one edge, counts busy cycles until done
   task automatic run(input cmbt_pkg::cmbt_req_t q);
      int k;
      k = 0;
      while (ready_reg !== 1'b1 && k < 8)
      begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      @(posedge clk_sys);
      issue_valid <= 1'b1;
      issue_req <= q;
      @(posedge clk_sys);
      issue_valid <= 1'b0;
      #1;
      k = 0;
      while (done_reg !== 1'b1 && k < 8)
      begin
         check("ready while busy", ready_reg, 1'b0);
         @(posedge clk_sys);
         #1;
         k++;
      end
      check("ready at done", ready_reg, 1'b1);
      n = k;
      r = res_reg;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic chk_reset;
      check("ready in reset", ready_reg, 1'b0);
      check("len in reset", len_reg, 2'h1);
      check("cyc in reset", cyc_reg, 2'h1);
      check("acc in reset", res_reg.acc, 8'h00);
   endtask

   // Every operation of the set, one after another, timed at the ports
   task automatic time_all;
      cmbt_pkg::cmbt_op_t o;
      logic [3:0] e;
      o = o.first();
      repeat (o.num())
      begin
         e = exp_time(o);
         run(mk(o, 8'h21, 8'h42, 8'h13, 16'h0100, 1'b0));
         check({o.name(), " len"}, len_reg, e[3:2]);
         check({o.name(), " cyc"}, cyc_reg, e[1:0]);
         check({o.name(), " busy"}, n[15:0], {14'h0, e[1:0]});
         o = o.next();
      end
   endtask

   task automatic acc_ops;
      run(mk(cmbt_pkg::OP_MOV_A_REG, 8'ha5, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("mov acc", r.acc, 8'ha5);
      run(mk(cmbt_pkg::OP_COMP_ACC, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("complement acc", r.acc, 8'h5a);
      run(mk(cmbt_pkg::OP_SWAP_ACC, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("swap acc", r.acc, 8'ha5);
      run(mk(cmbt_pkg::OP_EXCH_REG, 8'h3c, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("exchange acc", r.acc, 8'h3c);
      check("exchange dst", {r.dst_we, r.dst}, 9'h1a5);
   endtask

   // Only the low nibbles trade places; both high nibbles stay
   task automatic nibble;
      run(mk(cmbt_pkg::OP_MOV_A_REG, 8'h5a, 8'h00, 8'h00, 16'h0000, 1'b0));
      run(mk(cmbt_pkg::OP_NIB_EXCH, 8'h3c, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("nibble acc", r.acc, 8'h5c);
      check("nibble dst", {r.dst_we, r.dst}, 9'h13a);
   endtask

   // Pointer load, then code and external addresses, one with carry out of 16 bits
   task automatic pointer_addr;
      run(mk(cmbt_pkg::OP_MOV_A_REG, 8'h5c, 8'h00, 8'h00, 16'h0000, 1'b0));
      run(mk(cmbt_pkg::OP_MOV_DP_IMM16, 8'h12, 8'h34, 8'h00, 16'h0000, 1'b0));
      check("pointer", r.dp, 16'h1234);
      run(mk(cmbt_pkg::OP_CODE_RD_DP, 8'h77, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("code addr pointer", r.addr, 16'h1290);
      check("code data", r.acc, 8'h77);
      run(mk(cmbt_pkg::OP_CODE_RD_PC, 8'h00, 8'h00, 8'h00, 16'hfff0, 1'b0));
      check("code addr pc", r.addr, 16'h0067);
      run(mk(cmbt_pkg::OP_EXT_RD_IND, 8'h11, 8'h00, 8'hc3, 16'h0000, 1'b0));
      check("ext addr 8", r.addr, 16'h00c3);
      check("ext data", r.acc, 8'h11);
      run(mk(cmbt_pkg::OP_EXT_WR_DP, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("ext addr 16", r.addr, 16'h1234);
   endtask

   // Carry and direct bit operations; the accumulator must not move
   task automatic carry_bits;
      run(mk(cmbt_pkg::OP_MOV_A_REG, 8'h66, 8'h00, 8'h00, 16'h0000, 1'b0));
      run(mk(cmbt_pkg::OP_SET_CARRY, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("set carry", {r.carry, r.acc}, 9'h166);
      run(mk(cmbt_pkg::OP_COMP_CARRY, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("comp carry", {r.carry, r.acc}, 9'h066);
      run(mk(cmbt_pkg::OP_COMP_CARRY, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0));
      run(mk(cmbt_pkg::OP_CLR_CARRY, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("clear carry", {r.carry, r.acc}, 9'h066);
      run(mk(cmbt_pkg::OP_SET_BIT, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("set bit", {r.bit_we, r.bit_out, r.carry}, 3'h6);
      run(mk(cmbt_pkg::OP_CLR_BIT, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b1));
      check("clear bit", {r.bit_we, r.bit_out}, 2'h2);
      run(mk(cmbt_pkg::OP_COMP_BIT, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b1));
      check("comp bit", {r.bit_we, r.bit_out}, 2'h2);
      run(mk(cmbt_pkg::OP_COMP_BIT, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("comp bit low", {r.bit_we, r.bit_out}, 2'h3);
   endtask

   // Operations that write a destination byte
   task automatic dst_ops;
      run(mk(cmbt_pkg::OP_PUSH_DIR, 8'h9e, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("push dst", {r.dst_we, r.dst}, 9'h19e);
      run(mk(cmbt_pkg::OP_POP_DIR, 8'h4b, 8'h00, 8'h00, 16'h0000, 1'b0));
      check("pop dst", {r.dst_we, r.dst}, 9'h14b);
      run(mk(cmbt_pkg::OP_XOR_DIR_IMM, 8'hf0, 8'h3c, 8'h00, 16'h0000, 1'b0));
      check("xor dst", {r.dst_we, r.dst}, 9'h1cc);
   endtask

   // A second request held through the busy cycle is ignored, then taken in the done cycle
   task automatic back_to_back;
      @(posedge clk_sys);
      issue_valid <= 1'b1;
      issue_req <= mk(cmbt_pkg::OP_MOV_A_REG, 8'h0f, 8'h00, 8'h00, 16'h0000, 1'b0);
      @(posedge clk_sys);
      issue_req <= mk(cmbt_pkg::OP_COMP_ACC, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0);
      @(posedge clk_sys);
      #1;
      check("first done", {done_reg, ready_reg, res_reg.acc}, 10'h30f);
      @(posedge clk_sys);
      issue_valid <= 1'b0;
      #1;
      check("second taken", {done_reg, ready_reg}, 2'h0);
      @(posedge clk_sys);
      #1;
      check("second done", {done_reg, res_reg.acc}, 9'h1f0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Verdict, main sequence and watchdog
   task automatic results;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (8) @(posedge clk_sys);
      #1;
      chk_reset();
      @(posedge clk_sys);
      sys_rst <= 1'b0;
      time_all();
      acc_ops();
      nibble();
      pointer_addr();
      carry_bits();
      dst_ops();
      back_to_back();
      results();
   end

   // About 270 cycles are expected; a hang is cut well beyond that
   initial
   begin
      #100000;
      mismatches++;
      results();
   end
endmodule
